// file: hw/tsf_defs.svh
// constants for the trace sram word formatter
`ifndef TSF_DEFS_SVH
`define TSF_DEFS_SVH
// ************************************************************
// geometry
// ************************************************************
`define TSF_GROUP_WIDTH   128
`define TSF_HDR_WIDTH     8
`define TSF_WORD_WIDTH    (`TSF_GROUP_WIDTH + `TSF_HDR_WIDTH)
`define TSF_STATE_COUNT   8
`define TSF_STATE_BITS    3
`define TSF_FIFO_DEPTH    0
`define TSF_ADDR_BITS     10
`define TSF_STAMP_WIDTH   64
`define TSF_COUNT_WIDTH   32
`define TSF_CYC_WIDTH     16
`define TSF_CYC_SEL_MAX   4'hE
`define TSF_SLOT_COUNT    4
`define TSF_SLOT_WIDTH    4
// ************************************************************
// header byte fields
// ************************************************************
`define TSF_HDR_CYC       7:6
`define TSF_HDR_OVW       5
`define TSF_HDR_STATE     4:2
`define TSF_HDR_TYPE      1:0
// ************************************************************
// register map (byte addresses) and fields
// ************************************************************
`define TSF_PADDR_BITS    8
`define TSF_REG_CTRL      8'h00
`define TSF_REG_TSCTRL    8'h04
`define TSF_REG_STATESEL  8'h08
`define TSF_REG_COUNTER_TRACE_SELECT    8'h0C
`define TSF_REG_STATUS    8'h10
`define TSF_CTRL_EN       0
`define TSF_CTRL_TS_EN    1
`define TSF_TSCTRL_SEL    3:0
`define TSF_SLOT_VALID    3
`define TSF_STATUS_OVW    31
`define TSF_CTRL_RST      2'h0
`define TSF_TSCTRL_RST    4'h0
`define TSF_STATESEL_RST  8'h00
`define TSF_COUNTER_TRACE_SELECT_RST    16'h0000
`endif

// file: hw/tsf_pkg.sv
// types and shared decode for the trace sram word formatter
`include "tsf_defs.svh"
`default_nettype none
package tsf_pkg;
	// payload type codes; code 2'h3 is reserved and never produced
	typedef enum logic [1:0] {
		PKT_COUNTER = 2'h0,
		PKT_GROUP   = 2'h1,
		PKT_STAMP   = 2'h2
	} packet_type_t;
	typedef logic [`TSF_STATE_BITS-1:0] state_num_t;
	// number of the highest set request bit
	function automatic state_num_t highest_set(input logic [`TSF_STATE_COUNT-1:0] v);
		state_num_t n;
		n = '0;
		for (int i = 0; i < `TSF_STATE_COUNT; i++) begin
			if (v[i]) n = state_num_t'(i);
		end
		return n;
	endfunction : highest_set
endpackage : tsf_pkg
`default_nettype wire

// file: hw/tsf_cycle_counter.sv
// free-running fine-grain cycle counter with two-bit window select
`include "tsf_defs.svh"
`default_nettype none
module tsf_cycle_counter (
	input  wire logic       i_mclk,       // analyzer clock
	input  wire logic       i_arst_n,     // async reset, active low
	input  wire logic [3:0] i_bit_select, // low bit of selected pair
	output logic      [1:0] o_fine_bits   // selected counter pair
);
	logic [`TSF_CYC_WIDTH-1:0] count_q; // free-running count
	logic [3:0]                sel;     // clamped select
	// ************************************************************
	// counter
	// ************************************************************
	// wraps silently, never stops
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			count_q <= '0;
		end else begin
			count_q <= count_q + 1'b1;
		end
	end
	// clamp so the pair stays inside the counter
	assign sel = (i_bit_select > `TSF_CYC_SEL_MAX) ? `TSF_CYC_SEL_MAX : i_bit_select;
	// pick two adjacent bits
	assign o_fine_bits = count_q[sel +: 2];
endmodule : tsf_cycle_counter
`default_nettype wire

// file: hw/tsf_priority_arbiter.sv
// chooses one trace write among coinciding trigger-state requests
`include "tsf_defs.svh"
`default_nettype none
module tsf_priority_arbiter (
	input  wire logic [`TSF_STATE_COUNT-1:0] i_valid,   // per-state requests
	output logic                             o_any,     // some request present
	output tsf_pkg::state_num_t              o_winner,  // state kept
	output logic                             o_dropped  // lower write lost to top state
);
	logic [`TSF_STATE_COUNT-1:0] below; // any request under bit i
	// ************************************************************
	// lower-request scan
	// ************************************************************
	assign below[0] = 1'b0;
	genvar g;
	generate
		for (g = 1; g < `TSF_STATE_COUNT; g++) begin : g_below
			assign below[g] = below[g-1] | i_valid[g-1];
		end
	endgenerate
	assign o_any    = |i_valid;
	// highest number always wins
	assign o_winner = tsf_pkg::highest_set(i_valid);
	// only meaningful without the simultaneous fifos
	assign o_dropped = (`TSF_FIFO_DEPTH == 0) &&
		i_valid[`TSF_STATE_COUNT-1] && below[`TSF_STATE_COUNT-1];
endmodule : tsf_priority_arbiter
`default_nettype wire

// file: hw/trace_sram_word_formatter.sv
// assembles header plus payload words for the trace sram write port
`include "tsf_defs.svh"
`default_nettype none
module trace_sram_word_formatter (
	// ************************************************************
	// clock and reset
	// ************************************************************
	input  wire logic                            i_mclk,
	input  wire logic                            i_arst_n,
	// ************************************************************
	// apb slave
	// ************************************************************
	input  wire logic                            i_psel,
	input  wire logic                            i_penable,
	input  wire logic                            i_pwrite,
	input  wire logic [`TSF_PADDR_BITS-1:0]      i_paddr,
	input  wire logic [31:0]                     i_pwdata,
	output logic      [31:0]                     o_prdata,
	output logic                                 o_pready,
	output logic                                 o_pslverr,
	// ************************************************************
	// trigger-state capture side
	// ************************************************************
	input  wire logic [`TSF_STATE_COUNT-1:0]     i_capture_valid,
	input  wire logic [`TSF_STATE_COUNT-1:0]     i_capture_counter,
	input  wire logic [`TSF_GROUP_WIDTH-1:0]     i_probed_signal_group,
	input  wire logic [`TSF_GROUP_WIDTH-1:0]     i_alt_signal_group,
	input  wire logic [`TSF_COUNT_WIDTH-1:0]     i_counter_value,
	input  wire logic [`TSF_COUNT_WIDTH-1:0]     i_alt_counter_value,
	input  wire logic [`TSF_STATE_COUNT-1:0]     i_fifo_overrun,
	// ************************************************************
	// timestamp source
	// ************************************************************
	input  wire logic                            i_stamp_request,
	input  wire logic [`TSF_STAMP_WIDTH-1:0]     i_stamp_value,
	output logic                                 o_stamp_taken,
	// ************************************************************
	// trace sram write port
	// ************************************************************
	output logic                                 o_sram_wr_en,
	output logic      [`TSF_ADDR_BITS-1:0]       o_sram_wr_addr,
	output logic      [`TSF_WORD_WIDTH-1:0]      o_sram_wr_data
);
	// ************************************************************
	// declarations
	// ************************************************************
	localparam int TOP = `TSF_STATE_COUNT - 1; // state with extra path

	logic [1:0]                  ctrl_q;      // enable, stamp enable
	logic [3:0]                  tsctrl_q;    // counter pair select
	logic [`TSF_STATE_COUNT-1:0] statesel_q;  // alternate_state_select
	logic [15:0]                 counter_trace_select_q;    // counter_trace_select slots
	logic                        ovw_seen_q;  // sticky overwrite status
	logic                        stamp_pend_q;// stamp waiting for a gap
	logic [`TSF_ADDR_BITS-1:0]   wr_addr_q;   // circular write pointer
	logic                        wr_en_q;     // write strobe
	logic [`TSF_WORD_WIDTH-1:0]  wr_data_q;   // word being written
	logic [31:0]                 rdata_q;     // registered read data

	logic                        cap_any;     // some capture request
	tsf_pkg::state_num_t         winner;      // state whose write stays
	logic                        dropped;     // lower write overwritten by top state
	logic [1:0]                  fine_bits;   // cycle counter pair
	logic                        running;     // writes allowed
	logic                        stamp_take;  // stamp goes this cycle
	logic [2:0]                  slot_info;   // hit flag and position
	logic                        is_counter;  // counter packet chosen
	logic                        ovw_bit;     // header bit 5
	logic [`TSF_HDR_WIDTH-1:0]   header;      // header byte
	logic [`TSF_GROUP_WIDTH-1:0] payload;     // payload bits
	logic                        apb_wr;      // write access phase
	logic                        apb_rd;      // read access phase
	logic                        apb_hit;     // mapped address

	// ************************************************************
	// helpers
	// ************************************************************
	// finds a state among the four counter slots
	function automatic logic [2:0] slot_lookup(
		input logic [15:0]         slots,
		input tsf_pkg::state_num_t st
	);
		logic [2:0] r;
		r = 3'h0;
		for (int s = `TSF_SLOT_COUNT - 1; s >= 0; s--) begin
			if (slots[s*`TSF_SLOT_WIDTH + `TSF_SLOT_VALID] &&
			    slots[s*`TSF_SLOT_WIDTH +: `TSF_STATE_BITS] == st) begin
				r = {1'b1, 2'(s)};
			end
		end
		return r;
	endfunction : slot_lookup

	// true when the offset is a mapped register
	function automatic logic reg_mapped(input logic [`TSF_PADDR_BITS-1:0] a);
		return (a == `TSF_REG_CTRL) || (a == `TSF_REG_TSCTRL) ||
		       (a == `TSF_REG_STATESEL) || (a == `TSF_REG_COUNTER_TRACE_SELECT) ||
		       (a == `TSF_REG_STATUS);
	endfunction : reg_mapped

	// ************************************************************
	// sub-blocks
	// ************************************************************
	// fine-grain time bits
	tsf_cycle_counter u_cycle (
		.i_mclk       (i_mclk),
		.i_arst_n     (i_arst_n),
		.i_bit_select (tsctrl_q),
		.o_fine_bits  (fine_bits)
	);

	// picks one write among coinciding states
	tsf_priority_arbiter u_arb (
		.i_valid   (i_capture_valid),
		.o_any     (cap_any),
		.o_winner  (winner),
		.o_dropped (dropped)
	);

	// ************************************************************
	// apb decode
	// ************************************************************
	// zero wait states: every access ends in its first access cycle
	assign apb_wr   = i_psel & i_penable & i_pwrite;
	assign apb_rd   = i_psel & i_penable & ~i_pwrite;
	assign apb_hit  = reg_mapped(i_paddr);
	assign o_pready = 1'b1;
	// unmapped offsets answer with an error
	assign o_pslverr = i_psel & i_penable & ~apb_hit;
	assign o_prdata  = rdata_q;

	// control registers written by software
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl_q     <= `TSF_CTRL_RST;
			tsctrl_q   <= `TSF_TSCTRL_RST;
			statesel_q <= `TSF_STATESEL_RST;
			counter_trace_select_q   <= `TSF_COUNTER_TRACE_SELECT_RST;
		end else if (apb_wr) begin
			unique case (i_paddr)
				`TSF_REG_CTRL:     ctrl_q     <= i_pwdata[1:0];
				`TSF_REG_TSCTRL:   tsctrl_q   <= i_pwdata[`TSF_TSCTRL_SEL];
				`TSF_REG_STATESEL: statesel_q <= i_pwdata[`TSF_STATE_COUNT-1:0];
				`TSF_REG_COUNTER_TRACE_SELECT:   counter_trace_select_q   <= i_pwdata[15:0];
				default: begin
					// status is read-only apart from its clear bit
				end
			endcase
		end
	end

	// read data latched in the setup cycle, valid in the access phase
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rdata_q <= '0;
		end else if (i_psel & ~i_penable & ~i_pwrite) begin
			unique case (i_paddr)
				`TSF_REG_CTRL:     rdata_q <= {30'h0, ctrl_q};
				`TSF_REG_TSCTRL:   rdata_q <= {28'h0, tsctrl_q};
				`TSF_REG_STATESEL: rdata_q <= {24'h0, statesel_q};
				`TSF_REG_COUNTER_TRACE_SELECT:   rdata_q <= {16'h0, counter_trace_select_q};
				`TSF_REG_STATUS:   rdata_q <= {ovw_seen_q, 21'h0, wr_addr_q};
				default:           rdata_q <= '0;
			endcase
		end
	end

	// sticky overwrite flag; a new drop wins over the clear
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ovw_seen_q <= 1'b0;
		end else if (running & cap_any & ovw_bit) begin
			ovw_seen_q <= 1'b1;
		end else if (apb_wr && i_paddr == `TSF_REG_STATUS && i_pwdata[`TSF_STATUS_OVW]) begin
			ovw_seen_q <= 1'b0;
		end
	end

	// ************************************************************
	// packet selection
	// ************************************************************
	assign running = ctrl_q[`TSF_CTRL_EN];
	// stamps only fill cycles without a capture
	assign stamp_take = running & ctrl_q[`TSF_CTRL_TS_EN] & ~cap_any &
		(stamp_pend_q | i_stamp_request);
	assign o_stamp_taken = stamp_take;
	// counter packet only when the state sits in a valid slot
	assign slot_info  = slot_lookup(counter_trace_select_q, winner);
	assign is_counter = i_capture_counter[winner] & slot_info[2];

	// bit 5 meaning depends on the fifo build
	always_comb begin
		if (`TSF_FIFO_DEPTH == 0) begin
			ovw_bit = dropped;
		end else begin
			ovw_bit = i_fifo_overrun[winner] & statesel_q[winner];
		end
	end

	// pending stamp request; nothing queues while trace or stamps are off
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			stamp_pend_q <= 1'b0;
		end else if (!(running & ctrl_q[`TSF_CTRL_TS_EN])) begin
			stamp_pend_q <= 1'b0;
		end else if (i_stamp_request & ~stamp_take) begin
			stamp_pend_q <= 1'b1;
		end else if (stamp_take) begin
			stamp_pend_q <= 1'b0;
		end
	end

	// ************************************************************
	// header and payload
	// ************************************************************
	// one header per word, type 11 never built
	always_comb begin
		header = '0;
		payload = '0;
		header[`TSF_HDR_CYC] = fine_bits;
		if (cap_any && is_counter) begin
			// counter trace: slot position replaces the state number
			header[`TSF_HDR_TYPE]  = tsf_pkg::PKT_COUNTER;
			header[`TSF_HDR_STATE] = {1'b0, slot_info[1:0]};
			header[`TSF_HDR_OVW]   = ovw_bit;
			payload[`TSF_COUNT_WIDTH-1:0] = (int'(winner) == TOP) ?
				i_alt_counter_value : i_counter_value;
		end else if (cap_any) begin
			// full signal group from the winning state
			header[`TSF_HDR_TYPE]  = tsf_pkg::PKT_GROUP;
			header[`TSF_HDR_STATE] = winner;
			header[`TSF_HDR_OVW]   = ovw_bit;
			payload = (int'(winner) == TOP) ?
				i_alt_signal_group : i_probed_signal_group;
		end else begin
			// timestamp, upper payload stays zero
			header[`TSF_HDR_TYPE] = tsf_pkg::PKT_STAMP;
			payload[`TSF_STAMP_WIDTH-1:0] = i_stamp_value;
		end
	end

	// ************************************************************
	// sram write port
	// ************************************************************
	// whole word registered in one cycle
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_en_q   <= 1'b0;
			wr_data_q <= '0;
		end else begin
			wr_en_q <= running & (cap_any | stamp_take);
			if (running & (cap_any | stamp_take)) begin
				wr_data_q <= {payload, header};
			end
		end
	end

	// circular address, advances after each word
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_addr_q <= '0;
		end else if (wr_en_q) begin
			wr_addr_q <= wr_addr_q + 1'b1;
		end
	end

	assign o_sram_wr_en   = wr_en_q;
	assign o_sram_wr_addr = wr_addr_q;
	assign o_sram_wr_data = wr_data_q;
endmodule : trace_sram_word_formatter
`default_nettype wire

// file: tb/tsf_props.sv
// concurrent checks on the formatter write port
`include "tsf_defs.svh"
`default_nettype none
module tsf_props (
	input wire logic                        i_mclk,
	input wire logic                        i_arst_n,
	input wire logic [`TSF_STATE_COUNT-1:0] i_capture_valid,
	input wire logic [`TSF_GROUP_WIDTH-1:0] i_alt_signal_group,
	input wire logic [`TSF_STAMP_WIDTH-1:0] i_stamp_value,
	input wire logic                        o_stamp_taken,
	input wire logic                        o_sram_wr_en,
	input wire logic [`TSF_WORD_WIDTH-1:0]  o_sram_wr_data
);
	timeunit 1ns;
	timeprecision 100ps;
	// *****
	// shorthands and clocking
	// *****
	wire logic [`TSF_WORD_WIDTH-1:0] wd = o_sram_wr_data; // written word
	wire logic [1:0]                 ty = wd[1:0];        // type field
	wire logic                       we = o_sram_wr_en;   // write strobe
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);
	type_legal_a: assert property (we |-> ty != 2'h3)
		else $error("reserved type written");
	word_cause_a: assert property (we |-> $past(|i_capture_valid) || $past(o_stamp_taken))
		else $error("word without a request one cycle before");
	top_wins_a: assert property (we && ty == 2'h1 && $past(i_capture_valid[7]) |-> wd[4:2] == 3'h7)
		else $error("top state not kept");
	ovw_set_a: assert property (we && ty == 2'h1 && $past(i_capture_valid[7]) |-> wd[5] == $past(|i_capture_valid[6:0]))
		else $error("overwrite flag wrong");
	ovw_clear_a: assert property (we && ty != 2'h2 && !$past(i_capture_valid[7]) |-> !wd[5])
		else $error("overwrite flag without top state");
	alt_payload_a: assert property (we && ty == 2'h1 && $past(i_capture_valid[7]) |-> wd[135:8] == $past(i_alt_signal_group))
		else $error("top state payload wrong");
	stamp_word_a: assert property (o_stamp_taken |=> we && ty == 2'h2 && wd[71:8] == $past(i_stamp_value))
		else $error("stamp word wrong");
	stamp_zero_a: assert property (we && ty == 2'h2 |-> wd[135:72] == '0)
		else $error("stamp not zero extended");
	count_ext_a: assert property (we && ty == 2'h0 |-> wd[135:40] == '0 && !wd[4])
		else $error("counter word wrong");
	stamp_gap_a: assert property (o_stamp_taken |-> !(|i_capture_valid))
		else $error("stamp taken during capture");
	cover property (we && wd[5]);
	cover property (we && ty == 2'h0);
	cover property (we && ty == 2'h2);
endmodule : tsf_props
bind trace_sram_word_formatter tsf_props tsf_props_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
	.i_capture_valid(i_capture_valid), .i_alt_signal_group(i_alt_signal_group), .i_stamp_value(i_stamp_value),
	.o_stamp_taken(o_stamp_taken), .o_sram_wr_en(o_sram_wr_en), .o_sram_wr_data(o_sram_wr_data));
`default_nettype wire

// file: tb/tsf_sram_model.sv
// trace sram model that stores each word at its write address, later words overwriting earlier ones there
`include "tsf_defs.svh"
`default_nettype none
module tsf_sram_model (
	input  wire logic                       i_mclk,
	input  wire logic                       i_arst_n,
	input  wire logic                       i_wr_en,
	input  wire logic [`TSF_ADDR_BITS-1:0]  i_wr_addr,
	input  wire logic [`TSF_WORD_WIDTH-1:0] i_wr_data,
	output logic      [15:0]                o_count
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [`TSF_WORD_WIDTH-1:0] mem [0:(1<<`TSF_ADDR_BITS)-1]; // group plus header byte per word
	// whole word stored in one cycle
	always_ff @(posedge i_mclk) begin
		if (i_wr_en) mem[i_wr_addr] <= i_wr_data;
	end
	// count of stored words
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) o_count <= 16'h0000;
		else if (i_wr_en) o_count <= o_count + 16'h0001;
	end
endmodule : tsf_sram_model
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the trace sram word formatter
`include "tsf_defs.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic [7:0] v; logic [7:0] c; logic [2:0] st; logic [1:0] ty; logic ow;} row_t;
	logic         i_mclk = 1'b0, i_arst_n = 1'b0;       // clock and reset
	logic         i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
	logic [7:0]   i_paddr = 8'h00;                      // register offset
	logic [31:0]  i_pwdata = 32'h0, o_prdata, rd;       // bus data
	logic         o_pready, o_pslverr, er, o_stamp_taken, o_sram_wr_en, i_stamp_request = 1'b0;
	logic [7:0]   i_capture_valid = 8'h00, i_capture_counter = 8'h00;
	logic [127:0] grp = 128'h0123456789ABCDEFFEDCBA9876543210, alt = 128'h55AA33CC0FF0123489ABCDEF76543210;
	logic [31:0]  cnt = 32'hC0FFEE01;                   // counter payload
	logic [63:0]  stamp = 64'hDEADBEEF01234567;         // timestamp payload
	logic [9:0]   o_sram_wr_addr, wa = 10'h000;         // expected next address
	logic [135:0] o_sram_wr_data, w;                    // written word
	logic [127:0] ep;                                   // expected payload
	logic [15:0]  n_words;                              // model word count
	logic [1:0]   b;                                    // expected cycle bits
	int           fail_count = 0, n_compared = 0, k;
	row_t rows [9] = '{'{8'h01, 8'h00, 3'h0, 2'h1, 1'b0}, '{8'h0A, 8'h00, 3'h3, 2'h1, 1'b0},
		'{8'h80, 8'h00, 3'h7, 2'h1, 1'b0}, '{8'h81, 8'h00, 3'h7, 2'h1, 1'b1}, '{8'hFF, 8'h00, 3'h7, 2'h1, 1'b1},
		'{8'h04, 8'h04, 3'h0, 2'h0, 1'b0}, '{8'h20, 8'h20, 3'h3, 2'h0, 1'b0}, '{8'h10, 8'h10, 3'h4, 2'h1, 1'b0},
		'{8'h80, 8'h80, 3'h2, 2'h0, 1'b0}};
	trace_sram_word_formatter trace_sram_word_formatter_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
		.o_pready(o_pready), .o_pslverr(o_pslverr), .i_capture_valid(i_capture_valid),
		.i_capture_counter(i_capture_counter), .i_probed_signal_group(grp), .i_alt_signal_group(alt),
		.i_counter_value(cnt), .i_alt_counter_value(~cnt), .i_fifo_overrun(8'h00),
		.i_stamp_request(i_stamp_request), .i_stamp_value(stamp), .o_stamp_taken(o_stamp_taken),
		.o_sram_wr_en(o_sram_wr_en), .o_sram_wr_addr(o_sram_wr_addr), .o_sram_wr_data(o_sram_wr_data));
	tsf_sram_model tsf_sram_model_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_wr_en(o_sram_wr_en),
		.i_wr_addr(o_sram_wr_addr), .i_wr_data(o_sram_wr_data), .o_count(n_words));
	// *****
	// clock and shared tasks
	// *****
	always #2 i_mclk = ~i_mclk;
	task automatic chk(input string nm, input logic [135:0] e, input logic [135:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : conclude
	// one apb transfer, held until pready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge i_mclk);
		i_psel <= 1'b1;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_mclk);
		i_penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge i_mclk);
			if (o_pready === 1'b1) break;
		end
		if (n == 20) begin
			fail_count++;
			conclude();
		end
		// answer taken at the edge where pready is seen high
		rd = o_prdata;
		er = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("register", e, rd);
		chk("mapped error", 136'h0, er);
	endtask : rdchk
	// capture request held for n cycles, then let the last word land
	task automatic cap(input logic [7:0] v, input logic [7:0] c, input int n);
		@(posedge i_mclk);
		i_capture_valid <= v;
		i_capture_counter <= c;
		repeat (n) @(posedge i_mclk);
		i_capture_valid <= 8'h00;
		@(posedge i_mclk);
		#1;
	endtask : cap
	// *****
	// main sequence
	// *****
	initial begin
		repeat (4) @(posedge i_mclk);
		i_arst_n <= 1'b1;
		for (k = 0; k < 5; k++) rdchk(8'(4 * k), 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped error", 136'h1, er);
		apb(1'b1, 8'h08, 32'h80);
		rdchk(8'h08, 32'h80);
		apb(1'b1, 8'h0C, 32'hDF0A);
		cap(8'h01, 8'h00, 1);
		chk("words while disabled", 136'h0, n_words);
		apb(1'b1, 8'h00, 32'h1);
		// table of single captures
		foreach (rows[i]) begin
			cap(rows[i].v, rows[i].c, 1);
			w = tsf_sram_model_i.mem[wa];
			chk("header", {rows[i].ow, rows[i].st, rows[i].ty}, w[5:0]);
			ep = rows[i].v[7] ? alt : grp;
			if (rows[i].ty == 2'h0) ep = {96'h0, rows[i].v[7] ? ~cnt : cnt};
			chk("payload", ep, w[135:8]);
			wa++;
		end
		rdchk(8'h10, {1'b1, 21'h0, wa});
		apb(1'b1, 8'h10, 32'h80000000);
		rdchk(8'h10, {22'h0, wa});
		// fine cycle bits step once per selected bit period
		for (int s = 0; s < 3; s++) begin
			apb(1'b1, 8'h04, 32'(s));
			cap(8'h01, 8'h00, (1 << s) + 1);
			b = tsf_sram_model_i.mem[wa][7:6] + 2'h1;
			chk("cycle bits", b, tsf_sram_model_i.mem[wa + 10'(1 << s)][7:6]);
			wa = wa + 10'((1 << s) + 1);
		end
		// stamp requested during back-to-back captures
		apb(1'b1, 8'h00, 32'h3);
		@(posedge i_mclk);
		i_capture_valid <= 8'h02;
		i_stamp_request <= 1'b1;
		@(posedge i_mclk);
		i_stamp_request <= 1'b0;
		@(posedge i_mclk);
		i_capture_valid <= 8'h00;
		for (k = 0; k < 20; k++) begin
			#1;
			if (o_stamp_taken === 1'b1) break;
			@(posedge i_mclk);
		end
		if (k == 20) begin
			fail_count++;
			conclude();
		end
		repeat (2) @(posedge i_mclk);
		#1;
		chk("capture type", 136'h1, tsf_sram_model_i.mem[wa + 10'h1][1:0]);
		w = tsf_sram_model_i.mem[wa + 10'h2];
		chk("stamp type", 136'h2, w[1:0]);
		chk("stamp payload", {64'h0, stamp}, w[135:8]);
		wa = wa + 10'h3;
		chk("address", wa, o_sram_wr_addr);
		// reset in mid run, asserted and released on rising edges
		@(posedge i_mclk);
		i_arst_n <= 1'b0;
		@(posedge i_mclk);
		#1;
		chk("ready in reset", 136'h1, o_pready);
		chk("strobe in reset", 136'h0, o_sram_wr_en);
		@(posedge i_mclk);
		i_arst_n <= 1'b1;
		@(posedge i_mclk);
		#1;
		chk("address after reset", 136'h0, o_sram_wr_addr);
		chk("data after reset", 136'h0, o_sram_wr_data);
		rdchk(8'h00, 32'h0);
		conclude();
	end
endmodule : testbench
`default_nettype wire
